// ===== hdl/nvsc_pkg.sv
// constants, types and helpers for the nvsram store/recall host controller
// assumes a single 125 mhz clock and an nvsram wired to the pin bundle
package nvsc_pkg;

   localparam int ADDR_W          = 13;
   localparam int DATA_W          = 8;
   localparam int TIMER_W         = 21;

   ////////////////////////////////////////////////////////////////////////
   // timing, in ns, and the cycle counts at 8 ns
   localparam int CLK_PERIOD_NS   = 8;
   localparam int READ_CYCLE_NS   = 45;    // slowest speed grade
   localparam int STORE_PULSE_NS  = 250;   // external_store_pulse_min
   localparam int ONSET_NS        = 1000;  // inhibit_onset_delay
   localparam int RELEASE_NS      = 25;    // inhibit_release_delay
   localparam int RECALL_NS       = 20000; // recall_duration
   localparam int STORE_NS        = 10000000; // store_duration

   // least times round up
   localparam int ACC_CYC    = (READ_CYCLE_NS + CLK_PERIOD_NS - 1)
                               / CLK_PERIOD_NS;
   localparam int PULSE_CYC  = (STORE_PULSE_NS + CLK_PERIOD_NS - 1)
                               / CLK_PERIOD_NS;
   localparam int ONSET_CYC  = (ONSET_NS + CLK_PERIOD_NS - 1)
                               / CLK_PERIOD_NS;
   localparam int REL_CYC    = (RELEASE_NS + CLK_PERIOD_NS - 1)
                               / CLK_PERIOD_NS;
   localparam int RECALL_CYC = (RECALL_NS + CLK_PERIOD_NS - 1)
                               / CLK_PERIOD_NS;
   localparam int STORE_CYC  = (STORE_NS + CLK_PERIOD_NS - 1)
                               / CLK_PERIOD_NS;

   ////////////////////////////////////////////////////////////////////////
   // six-step address sequence
   localparam logic [ADDR_W-1:0] SEQ_A0     = 13'h0000;
   localparam logic [ADDR_W-1:0] SEQ_A1     = 13'h1555;
   localparam logic [ADDR_W-1:0] SEQ_A2     = 13'h0aaa;
   localparam logic [ADDR_W-1:0] SEQ_A3     = 13'h1fff;
   localparam logic [ADDR_W-1:0] SEQ_A4     = 13'h10f0;
   localparam logic [ADDR_W-1:0] SEQ_STORE  = 13'h0f0f;
   localparam logic [ADDR_W-1:0] SEQ_RECALL = 13'h0f0e;
   localparam logic [2:0]        SEQ_LAST   = 3'h5;

   typedef enum logic [2:0] {
      NVSC_OP_READ   = 3'h0,
      NVSC_OP_WRITE  = 3'h1,
      NVSC_OP_SWSTO  = 3'h2,
      NVSC_OP_SWREC  = 3'h3,
      NVSC_OP_HWSTO  = 3'h4
   } nvsc_op_e;

   typedef enum logic [8:0] {
      NVSC_IDLE  = 9'h001,
      NVSC_SETUP = 9'h002,
      NVSC_STRB  = 9'h004,
      NVSC_GAP   = 9'h008,
      NVSC_HOLD  = 9'h010,
      NVSC_ONSET = 9'h020,
      NVSC_NVRUN = 9'h040,
      NVSC_LINE  = 9'h080,
      NVSC_RECOV = 9'h100
   } nvsc_state_e;

   // pins driven toward the nvsram
   typedef struct packed {
      logic              ce_n;
      logic              we_n;
      logic              oe_n;
      logic [ADDR_W-1:0] word_select_bus;
      logic [DATA_W-1:0] byte_lane_out;
      logic              byte_lane_oe;
      logic              store_busy_oe;
   } nvsc_pins_s;

   typedef struct packed {
      nvsc_op_e          op;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } nvsc_cmd_s;

   function automatic logic [ADDR_W-1:0] seq_addr(input logic [2:0] step,
                                                  input logic recall);
      logic [ADDR_W-1:0] a;
      a = SEQ_A0;
      case (step)
         3'h1: a = SEQ_A1;
         3'h2: a = SEQ_A2;
         3'h3: a = SEQ_A3;
         3'h4: a = SEQ_A4;
         3'h5: a = recall ? SEQ_RECALL : SEQ_STORE;
         default: a = SEQ_A0;
      endcase
      return a;
   endfunction

endpackage

// ===== hdl/nvsc_timer.sv
// down counter shared by every timed wait of the host controller
// assumes load is a one-cycle request; done is high once the count is spent
module nvsc_timer #(
   parameter int WIDTH = nvsc_pkg::TIMER_W
) (
   input  wire logic             clk_sys,
   input  wire logic             rst,
   input  wire logic             load,
   input  wire logic [WIDTH-1:0] load_val,
   output logic                  done
);

   if (WIDTH < 2) begin : g_bad_width
      $error("WIDTH too small for the count");
   end

   typedef struct packed {
      logic [WIDTH-1:0] cnt;
   } nvsc_tmr_s;

   nvsc_tmr_s st_ff;
   nvsc_tmr_s nxt_st;

   always_comb begin
      nxt_st = st_ff;
      if (load) begin
         nxt_st.cnt = load_val;
      end else if (st_ff.cnt != '0) begin
         nxt_st.cnt = st_ff.cnt - 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign done = (st_ff.cnt == '0);

endmodule

// ===== hdl/nvsc_host.sv
// host controller that drives an 8k x 8 nvsram through its pins
// assumes pin inputs are synchronous to clk_sys and the store/busy wire
// is resolved outside from store_busy_oe (low while driven)
////////////////////////////////////////////////////////////////////////////
module nvsc_host #(
   parameter int STORE_WAIT = nvsc_pkg::STORE_CYC
) (
   input  wire logic                         clk_sys,
   input  wire logic                         rst,
   input  wire logic                         cmd_valid,
   input  wire nvsc_pkg::nvsc_cmd_s          cmd,
   output logic                              cmd_ready,
   output logic                              rsp_valid,
   output logic [nvsc_pkg::DATA_W-1:0]       rsp_rdata,
   output nvsc_pkg::nvsc_pins_s              pins,
   input  wire logic [nvsc_pkg::DATA_W-1:0]  byte_lane_in,
   input  wire logic                         store_busy_in
);

   localparam int TW = nvsc_pkg::TIMER_W;

   // refuse waits that the shared timer cannot hold
   if (STORE_WAIT < 2 || STORE_WAIT >= (1 << TW)) begin : g_bad_wait
      $error("STORE_WAIT out of timer range");
   end

   typedef struct packed {
      nvsc_pkg::nvsc_state_e       state;
      nvsc_pkg::nvsc_cmd_s         cmd;
      logic [2:0]                  step;
      nvsc_pkg::nvsc_pins_s        pins;
      logic                        ready;
      logic                        rsp;
      logic [nvsc_pkg::DATA_W-1:0] rdata;
   } nvsc_host_s;

   nvsc_host_s      st_ff;
   nvsc_host_s      nxt_st;
   logic            tmr_load;
   logic [TW-1:0]   tmr_val;
   logic            tmr_done;

   function automatic logic is_seq(input nvsc_pkg::nvsc_op_e op);
      return op == nvsc_pkg::NVSC_OP_SWSTO || op == nvsc_pkg::NVSC_OP_SWREC;
   endfunction

   nvsc_timer #(
      .WIDTH (TW)
   ) u_timer (
      .clk_sys  (clk_sys),
      .rst      (rst),
      .load     (tmr_load),
      .load_val (tmr_val),
      .done     (tmr_done)
   );

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      nxt_st   = st_ff;
      tmr_load = 1'b0;
      tmr_val  = '0;
      nxt_st.rsp = 1'b0;
      case (st_ff.state)
         nvsc_pkg::NVSC_IDLE: begin
            // no new access while any device holds the shared line low
            nxt_st.ready = store_busy_in;
            if (cmd_valid && st_ff.ready) begin
               nxt_st.ready = 1'b0;
               nxt_st.cmd   = cmd;
               nxt_st.step  = 3'h0;
               if (cmd.op == nvsc_pkg::NVSC_OP_HWSTO) begin
                  nxt_st.pins.store_busy_oe = 1'b1;
                  tmr_load = 1'b1;
                  tmr_val  = TW'(nvsc_pkg::PULSE_CYC - 1);
                  nxt_st.state = nvsc_pkg::NVSC_HOLD;
               end else begin
                  nxt_st.pins.word_select_bus = is_seq(cmd.op)
                     ? nvsc_pkg::seq_addr(3'h0, 1'b0) : cmd.addr;
                  nxt_st.state = nvsc_pkg::NVSC_SETUP;
               end
            end
         end
         nvsc_pkg::NVSC_SETUP: begin
            // address settled a cycle before chip enable falls
            nxt_st.pins.ce_n = 1'b0;
            if (st_ff.cmd.op == nvsc_pkg::NVSC_OP_WRITE) begin
               nxt_st.pins.we_n          = 1'b0;
               nxt_st.pins.byte_lane_out = st_ff.cmd.wdata;
               nxt_st.pins.byte_lane_oe  = 1'b1;
            end else begin
               // sequence steps keep the gate high: its level is free
               nxt_st.pins.oe_n = is_seq(st_ff.cmd.op);
            end
            tmr_load = 1'b1;
            tmr_val  = TW'(nvsc_pkg::ACC_CYC - 1);
            nxt_st.state = nvsc_pkg::NVSC_STRB;
         end
         nvsc_pkg::NVSC_STRB: begin
            if (tmr_done) begin
               if (st_ff.cmd.op == nvsc_pkg::NVSC_OP_READ) begin
                  nxt_st.rdata = byte_lane_in;
               end
               nxt_st.pins.ce_n = 1'b1;
               nxt_st.pins.we_n = 1'b1;
               nxt_st.pins.oe_n = 1'b1;
               nxt_st.state = nvsc_pkg::NVSC_GAP;
            end
         end
         nvsc_pkg::NVSC_GAP: begin
            // data held one cycle past the rising strobe
            nxt_st.pins.byte_lane_oe = 1'b0;
            if (!is_seq(st_ff.cmd.op)) begin
               nxt_st.rsp   = 1'b1;
               nxt_st.ready = store_busy_in;
               nxt_st.state = nvsc_pkg::NVSC_IDLE;
            end else if (st_ff.step == nvsc_pkg::SEQ_LAST) begin
               // device now runs alone; wait out the full duration
               tmr_load = 1'b1;
               tmr_val  = (st_ff.cmd.op == nvsc_pkg::NVSC_OP_SWREC)
                  ? TW'(nvsc_pkg::RECALL_CYC) : TW'(STORE_WAIT);
               nxt_st.state = nvsc_pkg::NVSC_NVRUN;
            end else begin
               // steps go back to back so nothing can interleave
               nxt_st.step = st_ff.step + 3'h1;
               nxt_st.pins.word_select_bus = nvsc_pkg::seq_addr(
                  st_ff.step + 3'h1,
                  st_ff.cmd.op == nvsc_pkg::NVSC_OP_SWREC);
               nxt_st.state = nvsc_pkg::NVSC_SETUP;
            end
         end
         nvsc_pkg::NVSC_HOLD: begin
            if (tmr_done) begin
               nxt_st.pins.store_busy_oe = 1'b0;
               tmr_load = 1'b1;
               tmr_val  = TW'(nvsc_pkg::ONSET_CYC - nvsc_pkg::PULSE_CYC - 1);
               nxt_st.state = nvsc_pkg::NVSC_ONSET;
            end
         end
         nvsc_pkg::NVSC_ONSET: begin
            // device may still be serving sram until the onset passes
            if (tmr_done) begin
               nxt_st.state = nvsc_pkg::NVSC_LINE;
            end
         end
         nvsc_pkg::NVSC_NVRUN: begin
            if (tmr_done) begin
               nxt_st.state = nvsc_pkg::NVSC_LINE;
            end
         end
         nvsc_pkg::NVSC_LINE: begin
            // device holds the line through any software store, a hardware store only if written since the last one
            if (store_busy_in) begin
               tmr_load = 1'b1;
               tmr_val  = TW'(nvsc_pkg::REL_CYC - 1);
               nxt_st.state = nvsc_pkg::NVSC_RECOV;
            end
         end
         nvsc_pkg::NVSC_RECOV: begin
            if (tmr_done) begin
               nxt_st.rsp   = 1'b1;
               nxt_st.ready = store_busy_in;
               nxt_st.state = nvsc_pkg::NVSC_IDLE;
            end
         end
         default: begin
            nxt_st.state = nvsc_pkg::NVSC_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         st_ff <= '{state: nvsc_pkg::NVSC_IDLE,
                    cmd:   '{op: nvsc_pkg::NVSC_OP_READ, default: '0},
                    pins:  '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1,
                             default: '0},
                    default: '0};
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign cmd_ready = st_ff.ready;
   assign rsp_valid = st_ff.rsp;
   assign rsp_rdata = st_ff.rdata;
   assign pins      = st_ff.pins;

   ////////////////////////////////////////////////////////////////////////
   // checks
   logic [7:0] low_cnt_ff;
   always_ff @(posedge clk_sys) begin
      if (rst || !st_ff.pins.store_busy_oe) begin
         low_cnt_ff <= 8'h00;
      end else if (low_cnt_ff != 8'hff) begin
         low_cnt_ff <= low_cnt_ff + 8'h01;
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   pulse_width_a: assert property (
      $fell(pins.store_busy_oe) |-> low_cnt_ff >= 8'(nvsc_pkg::PULSE_CYC))
      else $error("store/busy pulse shorter than 250 ns");
   seq_we_high_a: assert property (
      (!pins.ce_n && is_seq(st_ff.cmd.op)) |-> pins.we_n)
      else $error("write strobe low during sequence step");
   ce_pulse_a: assert property (
      $fell(pins.ce_n) |-> (!pins.ce_n)[*6] ##1 pins.ce_n[*2])
      else $error("chip enable pulse not toggled per step");
   seq_addr_a: assert property (
      (!pins.ce_n && is_seq(st_ff.cmd.op)) |-> pins.word_select_bus ==
      nvsc_pkg::seq_addr(st_ff.step, st_ff.cmd.op == nvsc_pkg::NVSC_OP_SWREC))
      else $error("sequence address out of order");
   addr_stable_a: assert property (
      !pins.ce_n |-> $stable(pins.word_select_bus))
      else $error("address moved under chip enable");
   line_gate_a: assert property (
      st_ff.state == nvsc_pkg::NVSC_SETUP |-> $past(store_busy_in, 2))
      else $error("access started while line low");
   recover_wait_a: assert property (
      (st_ff.state == nvsc_pkg::NVSC_LINE && store_busy_in) |=>
      (st_ff.state == nvsc_pkg::NVSC_RECOV)[*4] ##1 rsp_valid)
      else $error("release wait not 4 cycles");

   sw_store_c: cover property (
      st_ff.state == nvsc_pkg::NVSC_NVRUN
      && st_ff.cmd.op == nvsc_pkg::NVSC_OP_SWSTO);
   sw_recall_c: cover property (
      st_ff.state == nvsc_pkg::NVSC_NVRUN
      && st_ff.cmd.op == nvsc_pkg::NVSC_OP_SWREC);
   hw_store_c: cover property ($fell(pins.store_busy_oe));
   read_c: cover property (rsp_valid
      && st_ff.cmd.op == nvsc_pkg::NVSC_OP_READ);

endmodule

// ===== test/nvsc_dev_model.sv
// pin-level behavioural model of the 8k x 8 nvsram, sampled on clk_sys
// assumes the bench resolves the store/busy wire with a pull-up
module nvsc_dev_model #(
   parameter int STORE_T  = 200,
   parameter int RECALL_T = 100
) (
   input  wire logic                   clk_sys,
   input  wire nvsc_pkg::nvsc_pins_s   pins,
   input  wire logic                   line_n,
   output logic [nvsc_pkg::DATA_W-1:0] data_out,
   output logic                        busy_oe = 1'b0,
   output logic                        nv_busy = 1'b0,
   output int                          stores = 0
);
   localparam logic [12:0] SEQ_TAB [6] = '{13'h0000, 13'h1555, 13'h0aaa,
                                          13'h1fff, 13'h10f0, 13'h0f0f};
   logic [7:0]  sram [8192];
   logic [7:0]  nv   [8192];
   logic [7:0]  pat = 8'h00;
   logic [12:0] a;
   logic [2:0]  step = 3'h0;
   logic        dirty = 1'b0;
   logic        ce_was_n = 1'b1;
   logic        strb_was_n = 1'b1;
   logic        rd;
   int          cnt = 0;

   initial begin
      for (int i = 0; i < 8192; i++) begin
         nv[i]   = i[7:0] ^ 8'h5a;
         sram[i] = nv[i];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // undriven data lines toggle so a stale value never passes as read data
   assign a        = pins.word_select_bus;
   assign rd       = !pins.ce_n && !pins.oe_n && pins.we_n && line_n
                     && !nv_busy;
   assign data_out = rd ? sram[a] : ~pat;

   task automatic start_nv(input logic to_nv);
      nv_busy <= 1'b1;
      if (to_nv) begin
         busy_oe <= 1'b1;
         cnt     <= STORE_T;
         dirty   <= 1'b0;
         stores  <= stores + 1;
         for (int i = 0; i < 8192; i++)
            nv[i] <= sram[i];
      end else begin
         cnt <= RECALL_T;
         for (int i = 0; i < 8192; i++)
            sram[i] <= nv[i];
      end
   endtask

   ////////////////////////////////////////////////////////////////////////
   always @(posedge clk_sys) begin
      // an unknown select at power-up must not pin the lines at x
      pat        <= (rd === 1'b1) ? data_out : ~pat;
      ce_was_n   <= pins.ce_n;
      strb_was_n <= pins.ce_n | pins.we_n;
      if (nv_busy) begin
         cnt <= cnt - 1;
         if (cnt <= 1) begin
            nv_busy <= 1'b0;
            busy_oe <= 1'b0;
         end
      end else if (!line_n) begin
         step <= 3'h0;
         if (dirty)
            start_nv(1'b1);
      end else if (!strb_was_n && (pins.ce_n | pins.we_n)) begin
         sram[a] <= pins.byte_lane_oe ? pins.byte_lane_out : ~pat;
         dirty   <= 1'b1;
         step    <= 3'h0;
      end else if (ce_was_n && !pins.ce_n && pins.we_n) begin
         if (step == 3'h5 && (a == 13'h0f0f || a == 13'h0f0e))
            start_nv(a == 13'h0f0f);
         else if (a == SEQ_TAB[step])
            step <= step + 3'h1;
         else
            step <= (a == 13'h0000) ? 3'h1 : 3'h0;
      end
   end
endmodule

// ===== test/nvsc_host_test.sv
// self-checking bench of the nvsram host controller and a pin-level model
// assumes a 125 mhz clock and a pull-up on the shared store/busy wire
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin fails++; \
   $display("BAD %0t got %0h expected %0h", $time, got, exp); end end
module nvsc_host_test;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int STORE_T = 200;

   logic                        clk_sys = 1'b0;
   logic                        rst = 1'b1;
   logic                        cmd_valid = 1'b0;
   nvsc_pkg::nvsc_cmd_s         cmd = '0;
   logic                        cmd_ready;
   logic                        rsp_valid;
   logic                        line_n;
   logic                        dev_oe;
   logic                        nv_busy;
   logic                        written = 1'b0;
   logic [nvsc_pkg::DATA_W-1:0] rsp_rdata;
   logic [nvsc_pkg::DATA_W-1:0] dev_data;
   logic [nvsc_pkg::DATA_W-1:0] q;
   nvsc_pkg::nvsc_pins_s        pins;
   logic [7:0]                  shadow [8192];
   logic [7:0]                  nv_exp [8192];
   logic [12:0]                 a;
   logic [12:0]                 pin_a;
   logic [31:0]                 seed = 32'h0038bbad;
   int                          stores;
   int                          store_cnt = 0;
   int                          lat;
   int                          low_run = 0;
   int                          fails = 0;
   int                          compares = 0;
   nvsc_pkg::nvsc_op_e          cur_op = nvsc_pkg::NVSC_OP_READ;

   always #4 clk_sys = ~clk_sys;
   // open drain wire with pull-up
   assign line_n = ~(pins.store_busy_oe | dev_oe);

   nvsc_host #(.STORE_WAIT(20)) uut (
      .clk_sys       (clk_sys),
      .rst           (rst),
      .cmd_valid     (cmd_valid),
      .cmd           (cmd),
      .cmd_ready     (cmd_ready),
      .rsp_valid     (rsp_valid),
      .rsp_rdata     (rsp_rdata),
      .pins          (pins),
      .byte_lane_in  (dev_data),
      .store_busy_in (line_n)
   );
   nvsc_dev_model #(.STORE_T(STORE_T)) dev (.clk_sys(clk_sys), .pins(pins),
      .line_n(line_n), .data_out(dev_data), .busy_oe(dev_oe),
      .nv_busy(nv_busy), .stores(stores));

   ////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] xorshift(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   // least answer time: the model's store time or the documented waits
   function automatic int min_lat(input nvsc_pkg::nvsc_op_e op, input logic w);
      // store starts at the sixth chip enable fall, then the release wait
      if (op == nvsc_pkg::NVSC_OP_SWSTO)
         return 5 * (nvsc_pkg::ACC_CYC + 2) + STORE_T + nvsc_pkg::REL_CYC;
      if (op == nvsc_pkg::NVSC_OP_SWREC)
         return 48 + nvsc_pkg::RECALL_CYC;
      return w ? STORE_T : nvsc_pkg::ONSET_CYC;
   endfunction

   task automatic give_verdict();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic do_cmd(input nvsc_pkg::nvsc_op_e op, input logic [12:0] ad,
                         input logic [7:0] d);
      int n;
      logic w;
      n = 0;
      w = written;
      cmd_valid = 1'b1;
      cmd.op    = op;
      cmd.addr  = ad;
      cmd.wdata = d;
      cur_op    = op;
      while (cmd_ready !== 1'b1 && n < 5000) begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      @(posedge clk_sys);
      #1;
      cmd_valid = 1'b0;
      `CHK(n < 5000, 1'b1)
      `CHK(cmd_ready, 1'b0)
      lat = 0;
      while (rsp_valid !== 1'b1 && lat < 5000) begin
         @(posedge clk_sys);
         #1;
         lat++;
      end
      `CHK(lat < 5000, 1'b1)
      q = rsp_rdata;
      if (op == nvsc_pkg::NVSC_OP_READ)
         `CHK(q, shadow[ad])
      if (op == nvsc_pkg::NVSC_OP_WRITE) begin
         shadow[ad] = d;
         written = 1'b1;
      end
      if (op == nvsc_pkg::NVSC_OP_SWSTO || (op == nvsc_pkg::NVSC_OP_HWSTO && w))
      begin
         nv_exp = shadow;
         written = 1'b0;
         store_cnt++;
      end
      if (op == nvsc_pkg::NVSC_OP_SWREC)
         shadow = nv_exp;
      `CHK(stores, store_cnt)
      if (op == nvsc_pkg::NVSC_OP_READ || op == nvsc_pkg::NVSC_OP_WRITE)
         `CHK(lat, 2 + nvsc_pkg::ACC_CYC)
      else
         `CHK(lat >= min_lat(op, w), 1'b1)
   endtask

   ////////////////////////////////////////////////////////////////////////
   // pin watch: chip enable pulses, stable address, no access while busy
   always @(posedge clk_sys) begin
      if (!rst && !pins.ce_n) begin
         low_run++;
         if (low_run > 1)
            `CHK(pins.word_select_bus, pin_a)
         if (low_run == 1)
            `CHK(nv_busy, 1'b0)
         if (cur_op inside {nvsc_pkg::NVSC_OP_SWSTO, nvsc_pkg::NVSC_OP_SWREC})
            `CHK(pins.we_n, 1'b1)
      end else if (low_run != 0) begin
         `CHK(low_run, nvsc_pkg::ACC_CYC)
         low_run = 0;
      end
      pin_a = pins.word_select_bus;
   end

   initial begin
      #(20000 * 8);
      fails++;
      give_verdict();
   end

   initial begin
      for (int i = 0; i < 8192; i++)
         shadow[i] = i[7:0] ^ 8'h5a;
      nv_exp = shadow;
      repeat (6) @(posedge clk_sys);
      #1;
      rst = 1'b0;
      `CHK(pins.ce_n, 1'b1)
      `CHK(pins.store_busy_oe, 1'b0)
      for (int i = 0; i < 24; i++) begin
         seed = xorshift(seed);
         a = (i < 2) ? {13{i[0]}} : seed[12:0];
         do_cmd(nvsc_pkg::NVSC_OP_WRITE, a, seed[20:13]);
         do_cmd(nvsc_pkg::NVSC_OP_READ, a, 8'h00);
         seed = xorshift(seed);
         do_cmd(nvsc_pkg::NVSC_OP_READ, seed[12:0], 8'h00);
      end
      do_cmd(nvsc_pkg::NVSC_OP_SWSTO, 13'h0000, 8'h00);
      do_cmd(nvsc_pkg::NVSC_OP_WRITE, a, ~shadow[a]);
      do_cmd(nvsc_pkg::NVSC_OP_SWREC, 13'h0000, 8'h00);
      do_cmd(nvsc_pkg::NVSC_OP_READ, a, 8'h00);
      do_cmd(nvsc_pkg::NVSC_OP_WRITE, a, seed[7:0]);
      do_cmd(nvsc_pkg::NVSC_OP_HWSTO, 13'h0000, 8'h00);
      do_cmd(nvsc_pkg::NVSC_OP_HWSTO, 13'h0000, 8'h00);
      do_cmd(nvsc_pkg::NVSC_OP_WRITE, a, ~seed[7:0]);
      do_cmd(nvsc_pkg::NVSC_OP_SWREC, 13'h0000, 8'h00);
      do_cmd(nvsc_pkg::NVSC_OP_READ, a, 8'h00);
      for (int i = 0; i < 8; i++) begin
         seed = xorshift(seed);
         do_cmd(nvsc_pkg::NVSC_OP_READ, seed[12:0], 8'h00);
      end
      give_verdict();
   end
endmodule
